// ==== umpa_datapath.sv ====
// Unsigned multiply, parallel absolute value and parallel byte add datapath
// Behaviour
// RL1: Decode pipe-0 unsigned multiply, special 011001
// RL2: Decode pipe-1 unsigned multiply, media 011001
// RL3: Pipe-0 product low/high sign-extended to regs
// RL4: Pipe-1 product into upper 64 bits
// RL5: Pipe-1 multiply runs on second pipeline
// RL6: Multiplies raise no arithmetic exception
// RL7: Omitted destination encodes register zero
// RL8: Sources must have bits 63..32 zero
// RL9: Multiply runs beside later independent instructions
// RL10: Stall product reads until multiply done
// RL11: Halfword abs of eight lanes
// RL12: Halfword 0x8000 gives 0x7FFF, no exception
// RL13: Word abs of four lanes
// RL14: Decode word abs, media group-1 101000
// RL15: Decode byte add, media group-0 01000
// RL16: Sixteen byte lanes added, low 8 bits
// RL17: Byte add discards carries, no exception
// RL18: Parallel ops use full 128 bits
// RL19: Word most-negative gives most-positive
`default_nettype none
module umpa_datapath
  import umpa_pkg::*;
#(
  parameter int MUL_CYCLES = MUL_LATENCY
) (
  input  wire logic         sys_clk_in,
  input  wire logic         resetn_in,
  input  wire logic         issue_valid_in,
  input  wire logic [31:0]  instr_in,
  input  wire logic [127:0] src_a_in,
  input  wire logic [127:0] src_b_in,
  input  wire logic         prod_read_p0_in,
  input  wire logic         prod_read_p1_in,
  output logic              stall_out,
  output logic              illegal_out,
  output logic              arith_exc_out,
  output logic              gpr_we_out,
  output logic [4:0]        gpr_waddr_out,
  output logic [127:0]      gpr_wdata_out,
  output logic              mul_busy_out,
  output logic [127:0]      bottom_product_reg,
  output logic [127:0]      upper_product_reg
);

  // ***********************
  // Lane arithmetic
  // ***********************
  function automatic logic [15:0] abs_half(input logic [15:0] v);
    logic [15:0] neg;
    neg = 16'h0 - v;
    if (v == 16'h8000) begin
      abs_half = 16'h7FFF;   // RL12
    end else begin
      abs_half = v[15] ? neg : v;
    end
  endfunction : abs_half

  function automatic logic [31:0] abs_word(input logic [31:0] v);
    logic [31:0] neg;
    neg = 32'h0 - v;
    if (v == 32'h8000_0000) begin
      abs_word = 32'h7FFF_FFFF;   // RL19
    end else begin
      abs_word = v[31] ? neg : v;
    end
  endfunction : abs_word

  // ***********************
  // Decode
  // ***********************
  logic [5:0] opc;
  logic [5:0] fn;
  logic [4:0] sub;
  logic [4:0] srca;
  umpa_op_e   op;

  assign opc  = instr_in[OPC_MSB:OPC_LSB];
  assign fn   = instr_in[FUNC_MSB:FUNC_LSB];
  assign sub  = instr_in[SUB_MSB:SUB_LSB];
  assign srca = instr_in[SRCA_MSB:SRCA_LSB];

  always_comb begin
    op = UMPA_OP_NONE;
    if (opc == OPC_SPECIAL && sub == SUB_ZERO && fn == FN_UNSIGNED_MULTIPLY_P0) begin
      op = UMPA_OP_MUL0;   // RL1
    end else if (opc == OPC_MEDIA && sub == SUB_ZERO && fn == FN_UNSIGNED_MULTIPLY_P0) begin
      op = UMPA_OP_MUL1;   // RL2
    end else if (opc == OPC_MEDIA && fn == FN_MEDIA_G1 && sub == SUB_ABS_WORD
                 && srca == SUB_ZERO) begin
      op = UMPA_OP_ABSW;   // RL14
    end else if (opc == OPC_MEDIA && fn == FN_MEDIA_G1 && sub == SUB_ABS_HALF
                 && srca == SUB_ZERO) begin
      op = UMPA_OP_ABSH;
    end else if (opc == OPC_MEDIA && sub == SUB_ADD_BYTE && fn == FN_MEDIA_G0) begin
      op = UMPA_OP_ADDB;   // RL15
    end
  end

  // ***********************
  // Interlock
  // ***********************
  logic [2:0] mul_cnt;
  logic       mul_pipe1;
  logic [4:0] mul_dest;
  logic [63:0] mul_prod;
  logic       mul_done;
  logic       fire;

  assign mul_busy_out = (mul_cnt != MUL_CNT_RST);
  assign mul_done     = (mul_cnt == 3'h1);
  // A second multiply or any product read waits for the pending one
  assign stall_out = issue_valid_in && mul_busy_out &&
                     (op == UMPA_OP_MUL0 || op == UMPA_OP_MUL1 ||
                      prod_read_p0_in || prod_read_p1_in);   // RL10
  assign fire = issue_valid_in && !stall_out;
  assign illegal_out = issue_valid_in && op == UMPA_OP_NONE;
  assign arith_exc_out = 1'b0;   // RL6 RL17

  // ***********************
  // Multiplier (runs beside the issue stream)
  // ***********************
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      mul_cnt   <= MUL_CNT_RST;
      mul_pipe1 <= 1'b0;
      mul_dest  <= 5'h0;
      mul_prod  <= PROD_RST;
    end else if (fire && (op == UMPA_OP_MUL0 || op == UMPA_OP_MUL1)) begin
      // Only the low words feed the product; upper bits are ignored
      mul_prod  <= {32'h0, src_a_in[31:0]} * {32'h0, src_b_in[31:0]};   // RL3
      mul_pipe1 <= (op == UMPA_OP_MUL1);   // RL5
      mul_dest  <= instr_in[DEST_MSB:DEST_LSB];
      mul_cnt   <= 3'(MUL_CYCLES);   // RL9
    end else if (mul_busy_out) begin
      mul_cnt <= mul_cnt - 3'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      bottom_product_reg <= WIDE_RST;
      upper_product_reg  <= WIDE_RST;
    end else if (mul_done) begin
      if (mul_pipe1) begin
        bottom_product_reg[127:64] <= {{32{mul_prod[31]}}, mul_prod[31:0]};   // RL4
        upper_product_reg[127:64]  <= {{32{mul_prod[63]}}, mul_prod[63:32]};  // RL4
      end else begin
        bottom_product_reg[63:0] <= {{32{mul_prod[31]}}, mul_prod[31:0]};   // RL3
        upper_product_reg[63:0]  <= {{32{mul_prod[63]}}, mul_prod[63:32]};  // RL3
      end
    end
  end

  // ***********************
  // Register file write port
  // ***********************
  logic [127:0] simd_res;
  always_comb begin
    simd_res = WIDE_RST;
    unique case (op)
      UMPA_OP_ABSH: for (int i = 0; i < 8; i++) begin
        simd_res[i*16 +: 16] = abs_half(src_b_in[i*16 +: 16]);   // RL11 RL18
      end
      UMPA_OP_ABSW: for (int i = 0; i < 4; i++) begin
        simd_res[i*32 +: 32] = abs_word(src_b_in[i*32 +: 32]);   // RL13
      end
      UMPA_OP_ADDB: for (int i = 0; i < 16; i++) begin
        simd_res[i*8 +: 8] = src_a_in[i*8 +: 8] + src_b_in[i*8 +: 8];   // RL16 RL17
      end
      UMPA_OP_NONE, UMPA_OP_MUL0, UMPA_OP_MUL1: simd_res = WIDE_RST;
    endcase
  end

  // A SIMD issue has the port; a same-cycle multiply completion would collide,
  // so the SIMD result is written the cycle after it issues and the multiply
  // result only when no SIMD op issues at that moment.
  logic simd_fire;
  assign simd_fire = fire && (op == UMPA_OP_ABSH || op == UMPA_OP_ABSW || op == UMPA_OP_ADDB);

  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      gpr_we_out    <= 1'b0;
      gpr_waddr_out <= 5'h0;
      gpr_wdata_out <= WIDE_RST;
    end else if (simd_fire) begin
      gpr_we_out    <= 1'b1;
      gpr_waddr_out <= instr_in[DEST_MSB:DEST_LSB];
      gpr_wdata_out <= simd_res;   // RL18
    end else if (mul_done) begin
      gpr_we_out    <= 1'b1;
      gpr_waddr_out <= mul_dest;   // RL7
      gpr_wdata_out <= {64'h0, {32{mul_prod[31]}}, mul_prod[31:0]};
    end else begin
      gpr_we_out <= 1'b0;
    end
  end

  // ***********************
  // Checks
  // ***********************
  property p_mul_latency;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (fire && op == UMPA_OP_MUL1) |=> mul_busy_out [*4] ##1 !mul_busy_out;
  endproperty
  a_mul_latency: assert property (p_mul_latency) else $error("multiply latency wrong"); // RL9

  property p_stall;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (issue_valid_in && mul_busy_out && prod_read_p1_in) |-> stall_out;
  endproperty
  a_stall: assert property (p_stall) else $error("product read not stalled"); // RL10

  property p_no_stall_idle;
    @(posedge sys_clk_in) disable iff (!resetn_in) !mul_busy_out |-> !stall_out;
  endproperty
  a_no_stall_idle: assert property (p_no_stall_idle) else $error("spurious stall"); // RL9

  // Product registers change at the fourth edge, so they are seen one edge later
  property p_p1_upper;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (fire && op == UMPA_OP_MUL1) |-> ##5
      bottom_product_reg[95:64] == 32'({32'h0, $past(src_a_in[31:0], 5)} *
                                       {32'h0, $past(src_b_in[31:0], 5)}) &&
      bottom_product_reg[127:96] == {32{bottom_product_reg[95]}};
  endproperty
  a_p1_upper: assert property (p_p1_upper) else $error("pipe-1 product wrong"); // RL4

  property p_p0_value;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (fire && op == UMPA_OP_MUL0) |-> ##5 upper_product_reg[63:0] ==
      {{32{mul_prod[63]}}, mul_prod[63:32]} && mul_prod ==
      {32'h0, $past(src_a_in[31:0], 5)} * {32'h0, $past(src_b_in[31:0], 5)};
  endproperty
  a_p0_value: assert property (p_p0_value) else $error("pipe-0 product wrong"); // RL3

  property p_absh_min;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (fire && op == UMPA_OP_ABSH && src_b_in[15:0] == 16'h8000) |=>
      gpr_wdata_out[15:0] == 16'h7FFF;
  endproperty
  a_absh_min: assert property (p_absh_min) else $error("halfword abs min wrong"); // RL12

  property p_absw_min;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (fire && op == UMPA_OP_ABSW && src_b_in[31:0] == 32'h8000_0000) |=>
      gpr_wdata_out[31:0] == 32'h7FFF_FFFF;
  endproperty
  a_absw_min: assert property (p_absw_min) else $error("word abs min wrong"); // RL19

  property p_addb;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (fire && op == UMPA_OP_ADDB) |=> gpr_we_out &&
      gpr_wdata_out[127:120] == 8'($past(src_a_in[127:120]) + $past(src_b_in[127:120]));
  endproperty
  a_addb: assert property (p_addb) else $error("byte add wrong"); // RL16

  property p_no_exc;
    @(posedge sys_clk_in) disable iff (!resetn_in) !arith_exc_out;
  endproperty
  a_no_exc: assert property (p_no_exc) else $error("exception raised"); // RL6

  // Decode is checked from the raw fields, not from the decoded op
  property p_mul0_pipe;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (fire && opc == OPC_SPECIAL && sub == SUB_ZERO && fn == FN_UNSIGNED_MULTIPLY_P0) |=>
      mul_busy_out && !mul_pipe1;
  endproperty
  a_mul0_pipe: assert property (p_mul0_pipe) else $error("pipe-0 multiply not started"); // RL1

  property p_mul1_pipe;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (fire && opc == OPC_MEDIA && sub == SUB_ZERO && fn == FN_UNSIGNED_MULTIPLY_P0) |=>
      mul_busy_out && mul_pipe1;
  endproperty
  a_mul1_pipe: assert property (p_mul1_pipe) else $error("pipe-1 multiply not started"); // RL2

  property p_absw_dec;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (fire && opc == OPC_MEDIA && fn == FN_MEDIA_G1 && sub == SUB_ABS_WORD
       && srca == SUB_ZERO) |=> gpr_we_out;
  endproperty
  a_absw_dec: assert property (p_absw_dec) else $error("word abs not decoded"); // RL14

  property p_addb_dec;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (fire && opc == OPC_MEDIA && fn == FN_MEDIA_G0 && sub == SUB_ADD_BYTE) |=> gpr_we_out;
  endproperty
  a_addb_dec: assert property (p_addb_dec) else $error("byte add not decoded"); // RL15

  property p_absh_lane;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (fire && op == UMPA_OP_ABSH && !src_b_in[127]) |=>
      gpr_wdata_out[127:112] == $past(src_b_in[127:112]);
  endproperty
  a_absh_lane: assert property (p_absh_lane) else $error("halfword abs lane wrong"); // RL11

  property p_absw_lane;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (fire && op == UMPA_OP_ABSW && !src_b_in[127]) |=>
      gpr_wdata_out[127:96] == $past(src_b_in[127:96]);
  endproperty
  a_absw_lane: assert property (p_absw_lane) else $error("word abs lane wrong"); // RL13

  property p_addb_low;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (fire && op == UMPA_OP_ADDB) |=>
      gpr_wdata_out[7:0] == 8'($past(src_a_in[7:0]) + $past(src_b_in[7:0]));
  endproperty
  a_addb_low: assert property (p_addb_low) else $error("byte add carry kept"); // RL17

  property p_wide_dest;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      simd_fire |=> gpr_we_out && gpr_waddr_out == $past(instr_in[DEST_MSB:DEST_LSB]);
  endproperty
  a_wide_dest: assert property (p_wide_dest) else $error("parallel op destination wrong"); // RL18

  // The multiply write-back leaves the upper doubleword of the destination clear
  property p_mul_wb;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (mul_done && !simd_fire) |=> gpr_we_out && gpr_wdata_out[127:64] == 64'h0 &&
      gpr_waddr_out == $past(mul_dest);
  endproperty
  a_mul_wb: assert property (p_mul_wb) else $error("multiply write-back wrong"); // RL3

  property p_stall_p0;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      (issue_valid_in && mul_busy_out && prod_read_p0_in) |-> stall_out;
  endproperty
  a_stall_p0: assert property (p_stall_p0) else $error("low product read not stalled"); // RL10

  c_mul0: cover property (@(posedge sys_clk_in) fire && op == UMPA_OP_MUL0);
  c_mul1_stall: cover property (@(posedge sys_clk_in) stall_out && prod_read_p1_in);
  c_absh: cover property (@(posedge sys_clk_in) fire && op == UMPA_OP_ABSH);
  c_addb: cover property (@(posedge sys_clk_in) fire && op == UMPA_OP_ADDB);

endmodule : umpa_datapath
`default_nettype wire

// ==== umpa_pkg.sv ====
// Package of constants for the unsigned multiply and parallel abs/add datapath
`default_nettype none
package umpa_pkg;
  // ***********************
  // Instruction fields
  // ***********************
  localparam int          OPC_MSB       = 31;
  localparam int          OPC_LSB       = 26;
  localparam int          SRCA_MSB      = 25;
  localparam int          SRCA_LSB      = 21;
  localparam int          SRCB_MSB      = 20;
  localparam int          SRCB_LSB      = 16;
  localparam int          DEST_MSB      = 15;
  localparam int          DEST_LSB      = 11;
  localparam int          SUB_MSB       = 10;
  localparam int          SUB_LSB       = 6;
  localparam int          FUNC_MSB      = 5;
  localparam int          FUNC_LSB      = 0;
  localparam logic [5:0]  OPC_SPECIAL   = 6'h00;
  localparam logic [5:0]  OPC_MEDIA     = 6'h1C;
  localparam logic [5:0]  FN_UNSIGNED_MULTIPLY_P0      = 6'h19;
  localparam logic [5:0]  FN_MEDIA_G1   = 6'h28;
  localparam logic [5:0]  FN_MEDIA_G0   = 6'h08;
  localparam logic [4:0]  SUB_ZERO      = 5'h00;
  localparam logic [4:0]  SUB_ABS_WORD  = 5'h01;
  localparam logic [4:0]  SUB_ABS_HALF  = 5'h05;
  localparam logic [4:0]  SUB_ADD_BYTE  = 5'h08;
  // ***********************
  // Timing and reset values
  // ***********************
  localparam int          MUL_LATENCY   = 4;
  localparam logic [2:0]  MUL_CNT_RST   = 3'h0;
  localparam logic [63:0] PROD_RST      = 64'h0;
  localparam logic [127:0] WIDE_RST     = 128'h0;

  typedef enum logic [2:0] {
    UMPA_OP_NONE, UMPA_OP_MUL0, UMPA_OP_MUL1, UMPA_OP_ABSH, UMPA_OP_ABSW, UMPA_OP_ADDB
  } umpa_op_e;
endpackage : umpa_pkg
`default_nettype wire

// ==== umpa_regfile_model.sv ====
// Register file model that collects the datapath write-backs
`default_nettype none
module umpa_regfile_model (
  input  wire logic         sys_clk_in,
  input  wire logic         we_in,
  input  wire logic [4:0]   waddr_in,
  input  wire logic [127:0] wdata_in,
  input  wire logic [4:0]   raddr_in,
  output logic      [127:0] rdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [127:0] regs [32];
  // Entries start at zero so a missing write shows as a wrong value
  initial for (int i = 0; i < 32; i++) regs[i] = '0;
  always @(posedge sys_clk_in) if (we_in) regs[waddr_in] <= wdata_in;
  assign rdata_out = regs[raddr_in];
endmodule : umpa_regfile_model
`default_nettype wire

// ==== unsigned_mult_parallel_abs_add_test.sv ====
// Self-checking bench for the multiply and parallel abs/add datapath
`default_nettype none
module unsigned_mult_parallel_abs_add_test
  import umpa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic         sys_clk_in, resetn_in, issue_valid_in, prod_read_p0_in, prod_read_p1_in;
  logic [31:0]  instr_in;
  logic [127:0] src_a_in, src_b_in, gpr_wdata_out, bottom_product_reg, upper_product_reg;
  logic [127:0] rdata, a, b;
  logic         stall_out, illegal_out, arith_exc_out, gpr_we_out, mul_busy_out;
  logic [4:0]   gpr_waddr_out;
  logic [132:0] notes [$];
  logic [132:0] e;
  int           bad_count, check_count, seed, n;

  umpa_datapath #(.MUL_CYCLES(4)) dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .issue_valid_in(issue_valid_in), .instr_in(instr_in), .src_a_in(src_a_in),
    .src_b_in(src_b_in), .prod_read_p0_in(prod_read_p0_in), .prod_read_p1_in(prod_read_p1_in),
    .stall_out(stall_out), .illegal_out(illegal_out), .arith_exc_out(arith_exc_out),
    .gpr_we_out(gpr_we_out), .gpr_waddr_out(gpr_waddr_out), .gpr_wdata_out(gpr_wdata_out),
    .mul_busy_out(mul_busy_out), .bottom_product_reg(bottom_product_reg),
    .upper_product_reg(upper_product_reg));
  umpa_regfile_model rf (.sys_clk_in(sys_clk_in), .we_in(gpr_we_out), .waddr_in(gpr_waddr_out),
    .wdata_in(gpr_wdata_out), .raddr_in(5'h05), .rdata_out(rdata));

  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  function automatic logic [31:0] mk(logic [5:0] op, logic [4:0] d, logic [4:0] s, logic [5:0] f);
    return {op, 10'h000, d, s, f};
  endfunction : mk

  // Lane reference: mode 0 byte add, 1 halfword abs, 2 word abs
  function automatic logic [127:0] ref_op(int m, logic [127:0] x, logic [127:0] y);
    logic [127:0] r;
    logic [15:0]  h;
    logic [31:0]  w;
    for (int i = 0; i < 16; i++) r[i*8 +: 8] = x[i*8 +: 8] + y[i*8 +: 8];
    if (m == 1) for (int i = 0; i < 8; i++) begin
      h = y[i*16 +: 16];
      r[i*16 +: 16] = (h == 16'h8000) ? 16'h7FFF : (h[15] ? -h : h);
    end
    if (m == 2) for (int i = 0; i < 4; i++) begin
      w = y[i*32 +: 32];
      r[i*32 +: 32] = (w == 32'h80000000) ? 32'h7FFFFFFF : (w[31] ? -w : w);
    end
    return r;
  endfunction : ref_op

  task automatic chk(string nm, logic [127:0] ex, logic [127:0] got);
    check_count++;
    if (got !== ex) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic wrap_up();
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // Holds the request until it is taken; valid stays up for a back-to-back call
  task automatic issue(logic [31:0] ins, logic [127:0] xa, logic [127:0] xb, logic rd1,
                       output int w);
    w = 0;
    @(negedge sys_clk_in);
    issue_valid_in <= 1'b1;
    instr_in <= ins;
    src_a_in <= xa;
    src_b_in <= xb;
    prod_read_p1_in <= rd1;
    // Stall is judged between edges, where it has settled for the coming edge
    #1;
    while (stall_out !== 1'b0 && w < 20) begin
      w++;
      @(posedge sys_clk_in);
      #1;
    end
    @(posedge sys_clk_in);
    if (w >= 20) begin
      chk("issue_timeout", 0, 1);
      wrap_up();
    end
  endtask : issue

  task automatic idle();
    @(negedge sys_clk_in);
    issue_valid_in <= 1'b0;
    prod_read_p1_in <= 1'b0;
  endtask : idle

  always @(posedge sys_clk_in) begin
    #1;
    if (gpr_we_out === 1'b1) begin
      e = (notes.size() > 0) ? notes.pop_front() : '1;
      chk("gpr_waddr", e[132:128], gpr_waddr_out);
      chk("gpr_wdata", e[127:0], gpr_wdata_out);
      chk("arith_exc", 0, arith_exc_out);
    end
  end

  initial begin
    seed = 16;
    bad_count = 0;
    check_count = 0;
    {resetn_in, issue_valid_in, prod_read_p0_in, prod_read_p1_in} = 4'h0;
    {instr_in, src_a_in, src_b_in} = '0;
    repeat (20) @(posedge sys_clk_in);
    @(negedge sys_clk_in) resetn_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? {16{8'hFF}} : {$random(seed), $random(seed), $random(seed), $random(seed)};
      b = (i == 0) ? {16{8'h01}} : {$random(seed), $random(seed), $random(seed), $random(seed)};
      notes.push_back({5'(i + 1), ref_op(0, a, b)});
      issue(mk(OPC_MEDIA, 5'(i + 1), SUB_ADD_BYTE, FN_MEDIA_G0), a, b, 1'b0, n);
    end
    b = {$random(seed), 16'h8000, 16'h0001, 16'hFFFF, 16'h7FFF, $random(seed)};
    notes.push_back({5'h07, ref_op(1, a, b)});
    issue(mk(OPC_MEDIA, 5'h07, SUB_ABS_HALF, FN_MEDIA_G1), a, b, 1'b0, n);
    b = {32'h80000000, 32'hFFFFFFFF, 32'h7FFFFFFF, $random(seed)};
    notes.push_back({5'h08, ref_op(2, a, b)});
    issue(mk(OPC_MEDIA, 5'h08, SUB_ABS_WORD, FN_MEDIA_G1), a, b, 1'b0, n);
    // Destination omitted, so field zero; upper source bits kept zero
    issue(mk(OPC_SPECIAL, 5'h00, SUB_ZERO, FN_UNSIGNED_MULTIPLY_P0), 128'h80000000, 128'h3, 1'b0, n);
    notes.push_back({5'h09, ref_op(0, a, b)});
    issue(mk(OPC_MEDIA, 5'h09, SUB_ADD_BYTE, FN_MEDIA_G0), a, b, 1'b0, n);
    notes.push_back({5'h00, 64'h0, 64'hFFFFFFFF80000000});
    idle();
    repeat (6) @(negedge sys_clk_in);
    chk("bottom_p0", 64'hFFFFFFFF80000000, bottom_product_reg[63:0]);
    chk("upper_p0", 64'h1, upper_product_reg[63:0]);
    issue(mk(OPC_MEDIA, 5'h05, SUB_ZERO, FN_UNSIGNED_MULTIPLY_P0), 128'hFFFFFFFF, 128'hFFFFFFFF, 1'b0, n);
    #1 chk("mul_busy", 1, mul_busy_out);
    notes.push_back({5'h05, 64'h0, 64'h1});
    // Product read offered while the multiply is pending
    issue(32'h0, '0, '0, 1'b1, n);
    #1 chk("illegal", 1, illegal_out);
    chk("stall_cycles", 1, (n >= 1 && n <= 4));
    idle();
    repeat (6) @(negedge sys_clk_in);
    chk("bottom_prod", {64'h1, 64'hFFFFFFFF80000000}, bottom_product_reg);
    chk("upper_prod", {64'hFFFFFFFFFFFFFFFE, 64'h1}, upper_product_reg);
    chk("regfile_r5", {64'h0, 64'h1}, rdata);
    chk("notes_left", 0, notes.size());
    wrap_up();
  end
endmodule : unsigned_mult_parallel_abs_add_test
`default_nettype wire
